// file: rtl/mcs_pkg.sv
// constants for the monitor configuration and snapshot register bank
// assumes a 100 MHz core clock and a serial-bus engine on its own clock
package mcs_pkg;
    // register and command codes
    localparam logic [7:0] ADDR_FULL_SNAP = 8'h00;
    localparam logic [7:0] ADDR_BUS_SET = 8'h12;
    localparam logic [7:0] ADDR_RANGE_PEND = 8'h13;
    localparam logic [7:0] ADDR_GEN_SNAP = 8'h14;
    localparam logic [7:0] ADDR_KEEP_SNAP = 8'h15;
    localparam logic [7:0] ADDR_PIN_TRACK = 8'h16;
    localparam logic [7:0] ADDR_CTRL_ACT = 8'h17;
    localparam logic [7:0] ADDR_RANGE_ACT = 8'h18;

    // bus settings fields
    localparam int BIT_POR_FLAG = 4;
    localparam int BIT_TIMEOUT_EN = 3;
    localparam int BIT_BYTE_COUNT_EN = 2;
    localparam int BIT_HIGH_SPEED = 0;

    // low-rate pin register fields
    localparam int BIT_PIN_LEVEL = 7;
    localparam int BIT_PIN_RISE = 6;
    localparam int BIT_PIN_FALL = 5;
    localparam int BIT_RST_RISE = 4;
    localparam int BIT_KEEP_RISE = 3;
    localparam int BIT_RST_FALL = 2;
    localparam int BIT_KEEP_FALL = 1;

    // range field encodings
    localparam logic [1:0] RANGE_UNIPOLAR = 2'h0;
    localparam logic [1:0] RANGE_BIPOLAR = 2'h1;
    localparam logic [1:0] RANGE_BIPOLAR_HALF = 2'h2;

    // control mirror layout
    localparam int CTRL_MODE_LSB = 12;
    localparam logic [1:0] AUTO_OFF = 2'h0;
    localparam logic [1:0] AUTO_RESET_ACC = 2'h1;

    // values after reset
    localparam logic [15:0] RST_CTRL = 16'h2520;
    localparam logic [3:0] RST_RANGE = 4'h0;
    localparam logic [3:0] RST_PIN_CTRL = 4'h0;

    // spike suppression widths in ns, as cycles of the core clock
    localparam int SYS_CLK_MHZ = 100;
    localparam int SPIKE_FM_NS = 50;
    localparam int SPIKE_HS_NS = 10;
    localparam int SPIKE_FM_CYC_I = (SPIKE_FM_NS * SYS_CLK_MHZ) / 1000;
    localparam int SPIKE_HS_CYC_I = (SPIKE_HS_NS * SYS_CLK_MHZ) / 1000;
    localparam logic [2:0] SPIKE_FM_CYC = 3'(SPIKE_FM_CYC_I);
    localparam logic [2:0] SPIKE_HS_CYC =
        3'((SPIKE_HS_CYC_I < 1) ? 1 : SPIKE_HS_CYC_I);
endpackage : mcs_pkg

// file: rtl/mcs_regs.sv
// configuration and snapshot register bank of a single-channel power monitor
// assumes the serial-bus engine runs on i_link_clk and presents decoded
// register accesses; the measurement datapath sits on i_sys_clk
//
// Notes on behaviour
// RQ1 - power-on flag (bit 4) set by reset, cleared by host, set only by reset
// RQ2 - bus settings bit 3 enables the bus timeout; default off
// RQ3 - bus settings bit 2 adds byte count to block reads; default off
// RQ4 - bit 0 selects high-speed mode and narrows spike filter 50 to 10 ns
// RQ5 - host writes the high-speed bit alone, never within a block write
// RQ6 - a write clearing the high-speed bit is refused yet still applied
// RQ7 - sense range field bits 3:2: unipolar, bipolar, bipolar half, reserved
// RQ8 - bus range field bits 1:0: unipolar, bipolar, bipolar half, reserved
// RQ9 - pending range becomes active only when a snapshot command executes
// RQ10 - command 14h snapshots results then clears accumulator and count
// RQ11 - command 15h snapshots results keeping accumulator running
// RQ12 - snapshot data valid from next conversion end until next snapshot
// RQ13 - pin register bit 7 shows the current low-rate pin level
// RQ14 - bit 6 set on pin rise, cleared by full or general snapshot
// RQ15 - bit 5 set on pin fall, cleared by full or general snapshot
// RQ16 - bits 4 and 2 enable resetting snapshots on rise and fall
// RQ17 - bits 3 and 1 enable non-resetting snapshots on rise and fall
// RQ18 - pin snapshots update results, activate nothing; resetting one clears
// RQ19 - both enabled on one edge: only the resetting snapshot runs
// RQ20 - pin control writes take effect after the next snapshot command
// RQ21 - active control loads at snapshot; sample mode waits conversion end
// RQ22 - unimplemented bits always read zero
// RQ23 - host snapshot commands ignored while auto-snapshot is enabled
// RQ24 - low-rate pin synchronised before level and edge detection
`timescale 1ns/1ps
module mcs_regs (
    // core clock and power-on reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // serial-bus side, link clock domain
    input wire logic i_link_clk,
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic i_acc_send,
    input wire logic [7:0] i_acc_addr,
    input wire logic [15:0] i_acc_wdata,
    output logic o_acc_busy,
    output logic o_acc_done,
    output logic o_acc_nack,
    output logic [15:0] o_acc_rdata,
    // datapath side, core clock domain
    input wire logic i_low_rate_pin,
    input wire logic i_conv_done,
    input wire logic [15:0] i_pending_control,
    output logic o_result_latch,
    output logic o_accum_clear,
    output logic o_results_valid,
    output logic [3:0] o_active_range,
    output logic [15:0] o_active_control,
    // bus engine settings, core clock domain
    output logic o_timeout_en,
    output logic o_byte_count_en,
    output logic o_high_speed_en,
    output logic [2:0] o_spike_max_cycles
);
    // ---------------- link domain: request capture ----------------
    logic link_req_tgl;
    logic link_write;
    logic link_send;
    logic [7:0] link_addr;
    logic [15:0] link_wdata;
    logic ack_s1;
    logic ack_s2;
    logic ack_prev;
    logic link_ack_edge;

    // ---------------- core domain ----------------
    logic req_s1;
    logic req_s2;
    logic req_prev;
    logic go;
    logic sys_ack_tgl;
    logic [15:0] rd_hold;
    logic nack_hold;

    logic por_flag;
    logic timeout_en;
    logic byte_count_en;
    logic high_speed_en;
    logic [3:0] range_pend;
    logic [3:0] range_act;
    logic [3:0] pin_ctrl_pend;
    logic [3:0] pin_ctrl_act;
    logic pin_rise_seen_flag;
    logic pin_fall_seen_flag;
    logic [15:0] ctrl_act;
    logic [3:0] mode_pend;
    logic mode_wait;
    logic snap_armed;

    logic pin_s1;
    logic pin_s2;
    logic pin_d;
    logic pin_rise;
    logic pin_fall;

    logic auto_on;
    logic cmd_full;
    logic cmd_gen;
    logic cmd_keep;
    logic any_cmd;
    logic lim_reset;
    logic lim_keep;
    logic auto_snap;
    logic next_latch;
    logic next_clear;
    logic [15:0] next_rdata;

    // link side holds the request stable until the core answers
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link_req_tgl <= 1'b0;
            link_write <= 1'b0;
            link_send <= 1'b0;
            link_addr <= 8'h00;
            link_wdata <= 16'h0000;
            o_acc_busy <= 1'b0;
        end else if (i_acc_valid && !o_acc_busy) begin
            link_req_tgl <= ~link_req_tgl;
            link_write <= i_acc_write;
            link_send <= i_acc_send;
            link_addr <= i_acc_addr;
            link_wdata <= i_acc_wdata;
            o_acc_busy <= 1'b1;
        end else if (link_ack_edge) begin
            o_acc_busy <= 1'b0;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_prev <= 1'b0;
        end else begin
            ack_s1 <= sys_ack_tgl;
            ack_s2 <= ack_s1;
            ack_prev <= ack_s2;
        end
    end

    assign link_ack_edge = ack_s2 ^ ack_prev;

    // answer words are loaded in the core domain on the same edge that toggles the ack
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_acc_done <= 1'b0;
            o_acc_nack <= 1'b0;
            o_acc_rdata <= 16'h0000;
        end else begin
            o_acc_done <= link_ack_edge;
            if (link_ack_edge) begin
                o_acc_nack <= nack_hold;
                o_acc_rdata <= rd_hold;
            end
        end
    end

    // ---------------- core domain: request crossing ----------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_prev <= 1'b0;
        end else begin
            req_s1 <= link_req_tgl;
            req_s2 <= req_s1;
            req_prev <= req_s2;
        end
    end

    assign go = req_s2 ^ req_prev;

    // low-rate pin, two stages before any use
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_d <= 1'b0;
        end else begin
            pin_s1 <= i_low_rate_pin; // RQ24
            pin_s2 <= pin_s1;
            pin_d <= pin_s2;
        end
    end

    assign pin_rise = pin_s2 & ~pin_d; // RQ24
    assign pin_fall = ~pin_s2 & pin_d; // RQ24

    // snapshot decode
    assign auto_on = (ctrl_act[1:0] != mcs_pkg::AUTO_OFF);
    assign cmd_full = go && link_send && !auto_on && // RQ23
        (link_addr == mcs_pkg::ADDR_FULL_SNAP);
    assign cmd_gen = go && link_send && !auto_on && // RQ23
        (link_addr == mcs_pkg::ADDR_GEN_SNAP);
    assign cmd_keep = go && link_send && !auto_on && // RQ23
        (link_addr == mcs_pkg::ADDR_KEEP_SNAP);
    assign any_cmd = cmd_full | cmd_gen | cmd_keep;

    assign lim_reset =
        (pin_rise & pin_ctrl_act[mcs_pkg::BIT_RST_RISE - 1]) | // RQ16
        (pin_fall & pin_ctrl_act[mcs_pkg::BIT_RST_FALL - 1]); // RQ16
    assign lim_keep = ~lim_reset & ( // RQ19
        (pin_rise & pin_ctrl_act[mcs_pkg::BIT_KEEP_RISE - 1]) | // RQ17
        (pin_fall & pin_ctrl_act[mcs_pkg::BIT_KEEP_FALL - 1])); // RQ17
    assign auto_snap = auto_on & i_conv_done;

    assign next_latch = any_cmd | lim_reset | lim_keep | auto_snap;
    assign next_clear = cmd_full | cmd_gen | lim_reset | // RQ10 RQ18
        (auto_snap && ctrl_act[1:0] == mcs_pkg::AUTO_RESET_ACC);

    // datapath strobes
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_result_latch <= 1'b0;
            o_accum_clear <= 1'b0;
        end else begin
            o_result_latch <= next_latch; // RQ10 RQ11 RQ18
            o_accum_clear <= next_clear; // RQ10 RQ11
        end
    end

    // results readable after a conversion completes, until next snapshot
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            snap_armed <= 1'b0;
            o_results_valid <= 1'b0;
        end else if (next_latch) begin
            snap_armed <= 1'b1; // RQ12
            o_results_valid <= 1'b0;
        end else if (snap_armed && i_conv_done) begin
            snap_armed <= 1'b0;
            o_results_valid <= 1'b1; // RQ12
        end
    end

    // bus settings register; live at once, no snapshot needed
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            por_flag <= 1'b1; // RQ1
            timeout_en <= 1'b0;
            byte_count_en <= 1'b0;
            high_speed_en <= 1'b0;
        end else if (go && link_write &&
                     link_addr == mcs_pkg::ADDR_BUS_SET) begin
            // a one written to the flag is ignored: only power-on sets it
            if (!link_wdata[mcs_pkg::BIT_POR_FLAG]) begin
                por_flag <= 1'b0; // RQ1
            end
            timeout_en <= link_wdata[mcs_pkg::BIT_TIMEOUT_EN]; // RQ2
            byte_count_en <= link_wdata[mcs_pkg::BIT_BYTE_COUNT_EN]; // RQ3
            high_speed_en <= link_wdata[mcs_pkg::BIT_HIGH_SPEED]; // RQ4 RQ6
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_timeout_en <= 1'b0;
            o_byte_count_en <= 1'b0;
            o_high_speed_en <= 1'b0;
            o_spike_max_cycles <= mcs_pkg::SPIKE_FM_CYC;
        end else begin
            o_timeout_en <= timeout_en; // RQ2
            o_byte_count_en <= byte_count_en; // RQ3
            o_high_speed_en <= high_speed_en; // RQ4
            o_spike_max_cycles <= high_speed_en ? mcs_pkg::SPIKE_HS_CYC
                                                : mcs_pkg::SPIKE_FM_CYC; // RQ4
        end
    end

    // pending registers written by the host
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            range_pend <= mcs_pkg::RST_RANGE;
            pin_ctrl_pend <= mcs_pkg::RST_PIN_CTRL;
        end else if (go && link_write) begin
            if (link_addr == mcs_pkg::ADDR_RANGE_PEND) begin
                range_pend <= link_wdata[3:0]; // RQ7 RQ8
            end
            if (link_addr == mcs_pkg::ADDR_PIN_TRACK) begin
                pin_ctrl_pend <= link_wdata[4:1]; // RQ20
            end
        end
    end

    // activation only by host snapshot commands, never by pin snapshots
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            range_act <= mcs_pkg::RST_RANGE;
            pin_ctrl_act <= mcs_pkg::RST_PIN_CTRL;
        end else if (any_cmd) begin
            range_act <= range_pend; // RQ9
            pin_ctrl_act <= pin_ctrl_pend; // RQ20 RQ18
        end
    end

    // sample mode waits for the running conversion to finish
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_act <= mcs_pkg::RST_CTRL;
            mode_pend <= mcs_pkg::RST_CTRL[15:12];
            mode_wait <= 1'b0;
        end else begin
            if (any_cmd) begin
                ctrl_act[11:0] <= i_pending_control[11:0]; // RQ21
                mode_pend <= i_pending_control[15:12];
                mode_wait <= 1'b1; // RQ21
            end else if (mode_wait && i_conv_done) begin
                ctrl_act[15:12] <= mode_pend; // RQ21
                mode_wait <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_active_range <= mcs_pkg::RST_RANGE;
            o_active_control <= mcs_pkg::RST_CTRL;
        end else begin
            o_active_range <= range_act;
            o_active_control <= ctrl_act;
        end
    end

    // edge flags: a new edge wins over a clearing snapshot
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_rise_seen_flag <= 1'b0;
            pin_fall_seen_flag <= 1'b0;
        end else begin
            if (pin_rise) begin
                pin_rise_seen_flag <= 1'b1; // RQ14
            end else if (cmd_full || cmd_gen) begin
                pin_rise_seen_flag <= 1'b0; // RQ14
            end
            if (pin_fall) begin
                pin_fall_seen_flag <= 1'b1; // RQ15
            end else if (cmd_full || cmd_gen) begin
                pin_fall_seen_flag <= 1'b0; // RQ15
            end
        end
    end

    // read mux; unmapped and unimplemented bits read zero
    always_comb begin
        next_rdata = 16'h0000;
        case (link_addr)
            mcs_pkg::ADDR_BUS_SET: begin
                next_rdata[mcs_pkg::BIT_POR_FLAG] = por_flag; // RQ1
                next_rdata[mcs_pkg::BIT_TIMEOUT_EN] = timeout_en;
                next_rdata[mcs_pkg::BIT_BYTE_COUNT_EN] = byte_count_en;
                next_rdata[mcs_pkg::BIT_HIGH_SPEED] = high_speed_en; // RQ22
            end
            mcs_pkg::ADDR_RANGE_PEND: begin
                next_rdata[3:0] = range_pend; // RQ22
            end
            mcs_pkg::ADDR_RANGE_ACT: begin
                next_rdata[3:0] = range_act; // RQ22
            end
            mcs_pkg::ADDR_PIN_TRACK: begin
                next_rdata[mcs_pkg::BIT_PIN_LEVEL] = pin_s2; // RQ13
                next_rdata[mcs_pkg::BIT_PIN_RISE] = pin_rise_seen_flag;
                next_rdata[mcs_pkg::BIT_PIN_FALL] = pin_fall_seen_flag;
                next_rdata[4:1] = pin_ctrl_pend; // RQ22
            end
            mcs_pkg::ADDR_CTRL_ACT: begin
                next_rdata = ctrl_act;
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // answer to the link side
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_ack_tgl <= 1'b0;
            rd_hold <= 16'h0000;
            nack_hold <= 1'b0;
        end else if (go) begin
            sys_ack_tgl <= ~sys_ack_tgl;
            rd_hold <= next_rdata;
            // the new setting is kept even though the transfer is refused
            nack_hold <= link_write &&
                (link_addr == mcs_pkg::ADDR_BUS_SET) &&
                !link_wdata[mcs_pkg::BIT_HIGH_SPEED]; // RQ6
        end
    end
endmodule : mcs_regs

// file: testbench/mcs_host_model.sv
// host side model: serial-bus engine offering decoded register accesses
// assumes one outstanding access and a free-running link clock
`timescale 1ns/1ps
module mcs_host_model (
    // link clock
    input wire logic i_link_clk,
    // request
    output logic o_acc_valid,
    output logic o_acc_write,
    output logic o_acc_send,
    output logic [7:0] o_acc_addr,
    output logic [15:0] o_acc_wdata,
    // answer
    input wire logic i_acc_busy,
    input wire logic i_acc_done,
    // wait budget ran out
    output logic o_hung
);
    initial begin
        o_acc_valid = 1'b0;
        o_acc_write = 1'b0;
        o_acc_send = 1'b0;
        o_acc_addr = 8'h00;
        o_acc_wdata = 16'h0000;
        o_hung = 1'b0;
    end
    // one register word per transfer keeps the speed bit out of block writes
    task automatic access(input logic w, s, input logic [7:0] a,
        input logic [15:0] d, input int gap);
        int n;
        n = 0;
        repeat (gap + 1) @(negedge i_link_clk);
        while (i_acc_busy !== 1'b0 && n < 20) begin
            @(negedge i_link_clk);
            n++;
        end
        o_acc_write = w;
        o_acc_send = s;
        o_acc_addr = a;
        o_acc_wdata = d;
        o_acc_valid = 1'b1;
        @(negedge i_link_clk);
        o_acc_valid = 1'b0;
        // released address, data and write lines flip so stale values never pass as data
        o_acc_addr = ~a;
        o_acc_wdata = ~d;
        o_acc_write = ~w;
        while (i_acc_done !== 1'b1 && n < 40) begin
            @(negedge i_link_clk);
            n++;
        end
        if (n >= 40)
            o_hung = 1'b1;
    endtask : access
endmodule : mcs_host_model

// file: testbench/mcs_regs_bench.sv
// self-checking bench for the configuration and snapshot register bank
// assumes the host model on the link port; core inputs driven directly
`timescale 1ns/1ps
module mcs_regs_bench;
    logic sys_clk, link_clk, rst_n, valid, wr, snd, busy, done, nack;
    logic pin, conv, latch, aclr, rvalid, to_en, bc_en, hs_en, hung;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, pend, actl, p, d;
    logic [3:0] arng, mode_old;
    logic [2:0] spike;
    logic [17:0] exp_q[$];
    logic [17:0] e;
    logic [3:0] rng [3] = '{4'h6, 4'h9, 4'h0};
    logic [7:0] cmd [3] = '{mcs_pkg::ADDR_GEN_SNAP, mcs_pkg::ADDR_KEEP_SNAP,
        mcs_pkg::ADDR_FULL_SNAP};
    int clrs [3] = '{1, 0, 1};
    int miscompares, cmp_count, n_latch, n_clear, l0, c0;

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    mcs_regs dut (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_link_clk(link_clk),
        .i_acc_valid(valid), .i_acc_write(wr), .i_acc_send(snd),
        .i_acc_addr(addr), .i_acc_wdata(wdata), .o_acc_busy(busy),
        .o_acc_done(done), .o_acc_nack(nack), .o_acc_rdata(rdata),
        .i_low_rate_pin(pin), .i_conv_done(conv),
        .i_pending_control(pend), .o_result_latch(latch),
        .o_accum_clear(aclr), .o_results_valid(rvalid),
        .o_active_range(arng), .o_active_control(actl),
        .o_timeout_en(to_en), .o_byte_count_en(bc_en),
        .o_high_speed_en(hs_en), .o_spike_max_cycles(spike)
    );
    mcs_host_model host (
        .i_link_clk(link_clk), .o_acc_valid(valid), .o_acc_write(wr),
        .o_acc_send(snd), .o_acc_addr(addr), .o_acc_wdata(wdata),
        .i_acc_busy(busy), .i_acc_done(done), .o_hung(hung)
    );

    task automatic check(input string what, input logic [15:0] x, y);
        cmp_count++;
        if (y !== x) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, x, y);
        end
    endtask : check
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // answers match, in order, the notes made at request time
    always @(negedge link_clk) begin
        if (done === 1'b1) begin
            e = exp_q.pop_front();
            check("nack", {15'h0, e[16]}, {15'h0, nack});
            if (e[17])
                check("read data", e[15:0], rdata);
        end
    end
    always @(negedge sys_clk) begin
        if (latch === 1'b1)
            n_latch++;
        if (aclr === 1'b1)
            n_clear++;
    end

    task automatic acc(input logic w, s, input logic [7:0] a,
        input logic [15:0] dd, input logic [17:0] x);
        exp_q.push_back(x);
        host.access(w, s, a, dd, $urandom_range(0, 3));
        check("host wait", 16'h0, {15'h0, hung});
        repeat (4) @(negedge sys_clk);
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        acc(1'b0, 1'b0, a, 16'h0, {2'b10, x});
    endtask : rd
    task automatic wrt(input logic [7:0] a, input logic [15:0] dd,
        input logic nk);
        acc(1'b1, 1'b0, a, dd, {1'b0, nk, 16'h0});
    endtask : wrt
    task automatic pulse_conv();
        @(negedge sys_clk);
        conv = 1'b1;
        @(negedge sys_clk);
        conv = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask : pulse_conv
    // kind 0 host command, 1 pin level c[0], 2 conversion end
    task automatic ev(input int kind, input logic [7:0] c, input int dl, dc);
        l0 = n_latch;
        c0 = n_clear;
        if (kind == 0)
            acc(1'b0, 1'b1, c, 16'h0, 18'h0);
        else if (kind == 1) begin
            @(negedge sys_clk);
            pin = c[0];
            repeat (8) @(negedge sys_clk);
        end else
            pulse_conv();
        check("latch count", 16'(dl), 16'(n_latch - l0));
        check("clear count", 16'(dc), 16'(n_clear - c0));
    endtask : ev
    // reset spans several link cycles so both domains see it
    task automatic do_reset();
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (4) @(negedge link_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
    endtask : do_reset

    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        pin = 1'b0;
        conv = 1'b0;
        pend = 16'h0000;
        miscompares = 0;
        cmp_count = 0;
        n_latch = 0;
        n_clear = 0;
        void'($urandom(11596));
        do_reset();
        rd(mcs_pkg::ADDR_BUS_SET, 16'h0010);
        rd(mcs_pkg::ADDR_RANGE_PEND, 16'h0000);
        rd(mcs_pkg::ADDR_PIN_TRACK, 16'h0000);
        rd(mcs_pkg::ADDR_CTRL_ACT, mcs_pkg::RST_CTRL);
        rd(8'h40, 16'h0000);
        $display("test reset values done");
        wrt(mcs_pkg::ADDR_BUS_SET, 16'h00FF, 1'b0);
        rd(mcs_pkg::ADDR_BUS_SET, 16'h001D);
        check("enables", 16'h0007, {13'h0, to_en, bc_en, hs_en});
        check("spike", {13'h0, mcs_pkg::SPIKE_HS_CYC}, {13'h0, spike});
        wrt(mcs_pkg::ADDR_BUS_SET, 16'h0000, 1'b1);
        rd(mcs_pkg::ADDR_BUS_SET, 16'h0000);
        check("enables", 16'h0000, {13'h0, to_en, bc_en, hs_en});
        $display("test bus settings done");
        mode_old = mcs_pkg::RST_CTRL[15:12];
        for (int k = 0; k < 3; k++) begin
            p = 16'($urandom());
            p[1:0] = mcs_pkg::AUTO_OFF;
            pend = p;
            d = 16'(($urandom() & 32'hFFF0) | 32'(rng[k]));
            wrt(mcs_pkg::ADDR_RANGE_PEND, d, 1'b0);
            rd(mcs_pkg::ADDR_RANGE_PEND, {12'h0, rng[k]});
            ev(0, cmd[k], 1, clrs[k]);
            check("range", {12'h0, rng[k]}, {12'h0, arng});
            check("ctrl", {4'h0, p[11:0]}, {4'h0, actl[11:0]});
            check("mode", {12'h0, mode_old}, {12'h0, actl[15:12]});
            check("valid", 16'h0, {15'h0, rvalid});
            pulse_conv();
            check("mode", {12'h0, p[15:12]}, {12'h0, actl[15:12]});
            check("valid", 16'h1, {15'h0, rvalid});
            mode_old = p[15:12];
        end
        $display("test host snapshots done");
        wrt(mcs_pkg::ADDR_PIN_TRACK, 16'h0010, 1'b0);
        ev(1, 8'h01, 0, 0);
        rd(mcs_pkg::ADDR_PIN_TRACK, 16'h00D0);
        ev(0, mcs_pkg::ADDR_KEEP_SNAP, 1, 0);
        rd(mcs_pkg::ADDR_PIN_TRACK, 16'h00D0);
        ev(1, 8'h00, 0, 0);
        rd(mcs_pkg::ADDR_PIN_TRACK, 16'h0070);
        ev(0, mcs_pkg::ADDR_GEN_SNAP, 1, 1);
        rd(mcs_pkg::ADDR_PIN_TRACK, 16'h0010);
        wrt(mcs_pkg::ADDR_RANGE_PEND, 16'h0005, 1'b0);
        ev(1, 8'h01, 1, 1);
        check("range", 16'h0000, {12'h0, arng});
        wrt(mcs_pkg::ADDR_PIN_TRACK, 16'h001A, 1'b0);
        ev(0, mcs_pkg::ADDR_FULL_SNAP, 1, 1);
        ev(1, 8'h00, 1, 0);
        ev(1, 8'h01, 1, 1);
        rd(mcs_pkg::ADDR_PIN_TRACK, 16'h00FA);
        $display("test low-rate pin done");
        pend[1:0] = mcs_pkg::AUTO_RESET_ACC;
        ev(0, mcs_pkg::ADDR_KEEP_SNAP, 1, 0);
        ev(0, mcs_pkg::ADDR_GEN_SNAP, 0, 0);
        ev(2, 8'h00, 1, 1);
        do_reset();
        rd(mcs_pkg::ADDR_BUS_SET, 16'h0010);
        check("ctrl", mcs_pkg::RST_CTRL, actl);
        $display("test auto snapshot and reset done");
        print_verdict();
    end
endmodule : mcs_regs_bench

// file: testbench/mcs_regs_sva.sv
// assertions on the ports of the configuration and snapshot register bank
// assumes free-running core and link clocks and an asynchronous reset
`timescale 1ns/1ps
module mcs_regs_sva (
    // clocks and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    // watched inputs
    input wire logic i_acc_valid,
    input wire logic i_conv_done,
    // watched outputs
    input wire logic o_acc_busy,
    input wire logic o_acc_done,
    input wire logic o_result_latch,
    input wire logic o_accum_clear,
    input wire logic o_results_valid,
    input wire logic [3:0] o_active_range,
    input wire logic [15:0] o_active_control,
    input wire logic o_high_speed_en,
    input wire logic [2:0] o_spike_max_cycles
);
    a_spike_width: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) $stable(o_high_speed_en) |->
        o_spike_max_cycles == (o_high_speed_en ? mcs_pkg::SPIKE_HS_CYC
        : mcs_pkg::SPIKE_FM_CYC)) else $error("spike width wrong");
    a_clear_with_latch: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) o_accum_clear |-> o_result_latch)
        else $error("accumulator clear without result latch");
    a_valid_after_conv: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) $rose(o_results_valid) |-> $past(i_conv_done))
        else $error("results valid rose without conversion end");
    a_range_at_snap: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) $changed(o_active_range) |->
        $past(o_result_latch)) else $error("range moved without snapshot");
    a_ctrl_at_snap: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) $changed(o_active_control[11:0]) |->
        $past(o_result_latch)) else $error("control moved without snapshot");
    a_auto_snap: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) i_conv_done && o_active_control[1:0] ==
        mcs_pkg::AUTO_RESET_ACC |-> ##[1:2] (o_result_latch && o_accum_clear))
        else $error("auto snapshot missing");
    a_done_pulse: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) o_acc_done |=> !o_acc_done)
        else $error("done longer than one link cycle");
    a_busy_ends_done: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) $fell(o_acc_busy) |-> o_acc_done)
        else $error("busy fell without done");
    a_answer_time: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) $rose(o_acc_busy) |-> ##[3:10] o_acc_done)
        else $error("answer late");
    a_take_busy: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) i_acc_valid && !o_acc_busy |=> o_acc_busy)
        else $error("request not taken");
endmodule : mcs_regs_sva

bind mcs_regs mcs_regs_sva u_sva (
    .i_sys_clk, .i_rst_n, .i_link_clk, .i_acc_valid, .i_conv_done,
    .o_acc_busy, .o_acc_done, .o_result_latch, .o_accum_clear,
    .o_results_valid, .o_active_range, .o_active_control,
    .o_high_speed_en, .o_spike_max_cycles
);
